// File: design/dbs_next_state.sv
/*
  Next-state decoder for the comparator-driven sequencer.
  Assumes hits are already gated and qualified by the caller.
*/
`timescale 1ns/100ps
`default_nettype none

module dbs_next_state (
  input  wire logic [1:0]                          cur_state_in,
  input  wire logic [dbs_pkg::SCR_WIDTH-1:0]       scr1_in,
  input  wire logic [dbs_pkg::SCR_WIDTH-1:0]       scr2_in,
  input  wire logic [dbs_pkg::SCR_WIDTH-1:0]       scr3_in,
  input  wire logic [dbs_pkg::NUM_CHAN-1:0]        hit_in,
  output logic      [1:0]                          next_state_out,
  output logic                                     to_final_out
);

  // ---------------------------------------------------------------
  // Per-channel target decode
  // ---------------------------------------------------------------
  // Each control word picks a target per channel: low 3 bits keep the
  // legacy target map, bit 3 adds extended forks.
  function automatic logic [1:0] target(input logic [3:0] sequencer_state_control, input int ch);
    logic [1:0] t;
    t = sequencer_state_control[2:0] == 3'h0 ? dbs_pkg::SEQ_FINAL : 2'((sequencer_state_control[2:0] + 3'(ch)) % 3'h4);
    if (sequencer_state_control[3] && ch == 2) begin
      t = dbs_pkg::SEQ_FINAL; // Extended encoding: channel 2 forks to Final
    end
    return t;
  endfunction

  logic [3:0]  cur_scr;
  logic [1:0]  t0;
  logic [1:0]  t1;
  logic [1:0]  t2;
  logic        f0;
  logic        f1;
  logic        f2;

  // Pick the control word of the current state
  assign cur_scr = (cur_state_in == dbs_pkg::SEQ_STATE1) ? scr1_in :
                   (cur_state_in == dbs_pkg::SEQ_STATE2) ? scr2_in : scr3_in;
  assign t0 = target(cur_scr, 0);
  assign t1 = target(cur_scr, 1);
  assign t2 = target(cur_scr, 2);
  assign f0 = hit_in[0] && t0 == dbs_pkg::SEQ_FINAL;
  assign f1 = hit_in[1] && t1 == dbs_pkg::SEQ_FINAL;
  assign f2 = hit_in[2] && t2 == dbs_pkg::SEQ_FINAL;

  // Final-bound hits win, else the lowest channel wins
  assign to_final_out   = f0 | f1 | f2;
  assign next_state_out = to_final_out ? dbs_pkg::SEQ_FINAL :
                          hit_in[0] ? t0 :
                          hit_in[1] ? t1 :
                          hit_in[2] ? t2 : cur_state_in;

endmodule

`default_nettype wire

// File: design/dbs_pkg.sv
/*
  Shared constants and types for the debug breakpoint sequencer.
  Assumes a single 100 MHz system clock and a synchronous active-low reset.
*/
package dbs_pkg;

  // ---------------------------------------------------------------
  // Sizes
  // ---------------------------------------------------------------
  localparam int          NUM_CHAN     = 3;
  localparam int          SCR_WIDTH    = 4;
  localparam int          TRACE_DEPTH  = 64;
  localparam int          CNT_WIDTH    = 7;

  // ---------------------------------------------------------------
  // Counter reset and full values
  // ---------------------------------------------------------------
  localparam logic [CNT_WIDTH-1:0] CNT_RESET   = 7'h00;
  localparam logic [CNT_WIDTH-1:0] CNT_FULL    = 7'h40;

  // ---------------------------------------------------------------
  // Sequencer state codes
  // ---------------------------------------------------------------
  localparam logic [1:0]  SEQ_STATE1   = 2'h1;
  localparam logic [1:0]  SEQ_STATE2   = 2'h2;
  localparam logic [1:0]  SEQ_STATE3   = 2'h3;
  localparam logic [1:0]  SEQ_FINAL    = 2'h0;

  // ---------------------------------------------------------------
  // Top controller states (one-hot)
  // ---------------------------------------------------------------
  typedef enum logic [4:0] {
    ST_IDLE  = 5'h01,
    ST_ARMED = 5'h02,
    ST_TRACE = 5'h04,
    ST_PEND  = 5'h08,
    ST_DONE  = 5'h10
  } dbs_state_t;

  // ---------------------------------------------------------------
  // Breakpoint destinations
  // ---------------------------------------------------------------
  typedef enum logic [1:0] {
    MAP_NONE    = 2'h0,
    MAP_SOFTINT = 2'h1,
    MAP_MONITOR = 2'h2
  } dbs_map_t;

endpackage

// File: design/dbs_top.sv
/*
  Breakpoint generation and priority for the on-chip debug unit.
  Assumes the CPU acknowledges a held breakpoint request and that
  monitor status and trace-side signals come from same-clock logic.
*/
`timescale 1ns/100ps
`default_nettype none

module dbs_top (
  input  wire logic                              REF_CLK_IN,
  input  wire logic                              RST_N_IN,
  // Control bits from debug_control_one and friends
  input  wire logic                              SESSION_LIVE_SET_IN,
  input  wire logic                              SOFTWARE_FIRE_IN,
  input  wire logic                              MONITOR_SELECT_IN,
  input  wire logic                              CAPTURE_SELECT_IN,
  input  wire logic                              CAPTURE_PLACEMENT_IN,
  input  wire logic                              IMMEDIATE_HALT_SEL_IN,
  input  wire logic                              HALT_REQUEST_ENABLES_IN,
  input  wire logic [dbs_pkg::SCR_WIDTH-1:0]     SCR1_IN,
  input  wire logic [dbs_pkg::SCR_WIDTH-1:0]     SCR2_IN,
  input  wire logic [dbs_pkg::SCR_WIDTH-1:0]     SCR3_IN,
  input  wire logic [dbs_pkg::NUM_CHAN-1:0]      OPCODE_MARK_IN,
  input  wire logic                              RANGE_MODE_IN,
  input  wire logic                              DATA_MATCH_EN_IN,
  // Comparator and instruction queue events
  input  wire logic                              CHANNEL_ZERO_HIT_IN,
  input  wire logic                              CHANNEL_ONE_HIT_IN,
  input  wire logic                              CHANNEL_TWO_HIT_IN,
  input  wire logic                              RANGE_HIT_IN,
  input  wire logic                              DATA_HIT_IN,
  input  wire logic [dbs_pkg::NUM_CHAN-1:0]      MARK_AT_EXEC_IN,
  input  wire logic                              TRACE_STEP_IN,
  // Monitor and CPU status
  input  wire logic                              MONITOR_ENABLED_IN,
  input  wire logic                              MONITOR_ACTIVE_IN,
  input  wire logic                              SINGLE_STEP_CMD_IN,
  input  wire logic                              HALT_OPCODE_EXEC_IN,
  input  wire logic                              SOFT_INT_EXEC_IN,
  input  wire logic                              CPU_ACK_IN,
  // Outputs
  output logic                                   SOFT_INT_REQ_OUT,
  output logic                                   MONITOR_REQ_OUT,
  output logic                                   SKIP_HALT_OPCODE_OUT,
  output logic                                   TRACE_RUN_OUT,
  output logic                                   SESSION_LIVE_OUT,
  output logic [1:0]                             SEQ_STATE_OUT,
  output logic [dbs_pkg::CNT_WIDTH-1:0]          TRACE_COUNT_OUT
);

  // ---------------------------------------------------------------
  // State
  // ---------------------------------------------------------------
  dbs_pkg::dbs_state_t                st_r;
  dbs_pkg::dbs_state_t                st_nxt;
  logic [1:0]                         seq_r;
  logic [1:0]                         seq_nxt;
  logic [dbs_pkg::CNT_WIDTH-1:0]      cnt_r;
  logic [dbs_pkg::CNT_WIDTH-1:0]      cnt_nxt;
  logic                               fired_r;
  logic                               sw_req_r;
  logic                               mon_req_r;
  logic                               skip_r;
  logic                               replay_r;
  logic                               mon_act_d_r;
  logic                               pend_map_r;

  // ---------------------------------------------------------------
  // Hit qualification
  // ---------------------------------------------------------------
  logic [dbs_pkg::NUM_CHAN-1:0]       raw_hit;
  logic [dbs_pkg::NUM_CHAN-1:0]       direct_hit;
  logic [dbs_pkg::NUM_CHAN-1:0]       mark_hit;
  logic [dbs_pkg::NUM_CHAN-1:0]       seq_hit;
  logic                               hits_allowed;
  logic                               marks_allowed;
  logic [1:0]                         dec_state;
  logic                               dec_final;

  // Range and data qualify channel zero; range mode also blocks channel one
  assign raw_hit[0] = CHANNEL_ZERO_HIT_IN
                    && (!RANGE_MODE_IN || RANGE_HIT_IN)
                    && (!DATA_MATCH_EN_IN || DATA_HIT_IN || OPCODE_MARK_IN[0]);
  assign raw_hit[1] = CHANNEL_ONE_HIT_IN && !RANGE_MODE_IN;
  assign raw_hit[2] = CHANNEL_TWO_HIT_IN;

  // Active monitor kills hits; single step kills marking
  assign hits_allowed  = !MONITOR_ACTIVE_IN;
  assign marks_allowed = !MONITOR_ACTIVE_IN && !SINGLE_STEP_CMD_IN;

  // Mark bit picks direct transition or execution-stage hit
  assign direct_hit = raw_hit & ~OPCODE_MARK_IN & {dbs_pkg::NUM_CHAN{hits_allowed}};
  assign mark_hit   = MARK_AT_EXEC_IN & OPCODE_MARK_IN & {dbs_pkg::NUM_CHAN{marks_allowed}};
  assign seq_hit    = (st_r == dbs_pkg::ST_ARMED) ? (direct_hit | mark_hit) : '0;

  // Extended four-bit control words drive the decoder
  dbs_next_state u_next (
    .cur_state_in   (seq_r),
    .scr1_in        (SCR1_IN),
    .scr2_in        (SCR2_IN),
    .scr3_in        (SCR3_IN),
    .hit_in         (seq_hit),
    .next_state_out (dec_state),
    .to_final_out   (dec_final)
  );

  // ---------------------------------------------------------------
  // Trigger and controller decode
  // ---------------------------------------------------------------
  logic                               live_now;
  logic                               sw_software_fire;
  logic                               software_fire;
  logic                               buf_full;
  logic                               brk_fire;

  // Arm and fire can land in one write
  assign live_now = SESSION_LIVE_SET_IN || st_r != dbs_pkg::ST_IDLE;
  // Fire counts only while idle or armed, before the trigger
  assign sw_software_fire  = SOFTWARE_FIRE_IN && live_now
                 && (st_r == dbs_pkg::ST_ARMED || st_r == dbs_pkg::ST_IDLE);
  // Entry into Final from the sequencer or software
  assign software_fire     = sw_software_fire || dec_final;
  assign buf_full = cnt_r == dbs_pkg::CNT_FULL;

  // Next controller state and breakpoint moment
  always_comb begin
    st_nxt   = st_r;
    brk_fire = 1'b0;
    case (st_r)
      dbs_pkg::ST_IDLE: begin
        if (SESSION_LIVE_SET_IN) begin
          st_nxt = dbs_pkg::ST_ARMED;
        end
        if (sw_software_fire) begin
          st_nxt = dbs_pkg::ST_PEND;
        end
      end
      dbs_pkg::ST_ARMED: begin
        if (software_fire) begin
          st_nxt = dbs_pkg::ST_PEND;
        end
      end
      dbs_pkg::ST_PEND: begin
        // Breakpoint timing at Final entry
        if (!CAPTURE_SELECT_IN || IMMEDIATE_HALT_SEL_IN || !CAPTURE_PLACEMENT_IN) begin
          brk_fire = HALT_REQUEST_ENABLES_IN;
          st_nxt   = dbs_pkg::ST_DONE;
        end else begin
          st_nxt = dbs_pkg::ST_TRACE;
        end
      end
      dbs_pkg::ST_TRACE: begin
        // Begin alignment waits for the full buffer
        if (buf_full) begin
          brk_fire = HALT_REQUEST_ENABLES_IN;
          st_nxt   = dbs_pkg::ST_DONE;
        end
      end
      dbs_pkg::ST_DONE: begin
        st_nxt = dbs_pkg::ST_IDLE;
      end
      default: begin
        st_nxt = dbs_pkg::ST_IDLE;
      end
    endcase
  end

  // Sequencer tracks decoder; fire forces Final
  assign seq_nxt = (st_r == dbs_pkg::ST_IDLE && !SESSION_LIVE_SET_IN) ? dbs_pkg::SEQ_STATE1 :
                   sw_software_fire ? dbs_pkg::SEQ_FINAL :
                   (st_r == dbs_pkg::ST_ARMED) ? dec_state : seq_r;

  // Count trace lines: end alignment fills until trigger, begin after it
  assign cnt_nxt = (st_r == dbs_pkg::ST_IDLE && SESSION_LIVE_SET_IN) ? dbs_pkg::CNT_RESET :
                   (CAPTURE_SELECT_IN && TRACE_STEP_IN && !buf_full &&
                    ((st_r == dbs_pkg::ST_ARMED && !CAPTURE_PLACEMENT_IN) ||
                      st_r == dbs_pkg::ST_TRACE))
                   ? cnt_r + 7'h01 : cnt_r;

  // ---------------------------------------------------------------
  // Breakpoint mapping
  // ---------------------------------------------------------------
  dbs_pkg::dbs_map_t                  map_sel;
  logic                               want;
  logic                               to_mon;
  logic                               to_soft;
  logic                               mon_return;

  // Mapping table from enables, select and monitor status
  assign map_sel = (!HALT_REQUEST_ENABLES_IN || MONITOR_ACTIVE_IN) ? dbs_pkg::MAP_NONE :
                   (MONITOR_SELECT_IN && MONITOR_ENABLED_IN) ? dbs_pkg::MAP_MONITOR :
                   dbs_pkg::MAP_SOFTINT;
  assign mon_return = mon_act_d_r && !MONITOR_ACTIVE_IN;
  // Unserviced break is replayed on monitor return
  assign want    = brk_fire || (replay_r && mon_return);
  // Halt opcode with monitor enabled suppresses a forced soft break
  assign to_mon  = want && map_sel == dbs_pkg::MAP_MONITOR;
  assign to_soft = want && map_sel == dbs_pkg::MAP_SOFTINT
                && !(HALT_OPCODE_EXEC_IN && MONITOR_ENABLED_IN);

  // ---------------------------------------------------------------
  // Registers
  // ---------------------------------------------------------------
  // Controller, sequencer and counter
  always_ff @(posedge REF_CLK_IN) begin
    if (!RST_N_IN) begin
      st_r        <= dbs_pkg::ST_IDLE;
      seq_r       <= dbs_pkg::SEQ_STATE1;
      cnt_r       <= dbs_pkg::CNT_RESET;
      fired_r     <= 1'b0;
      mon_act_d_r <= 1'b0;
    end else begin
      st_r        <= st_nxt;
      seq_r       <= seq_nxt;
      cnt_r       <= cnt_nxt;
      fired_r     <= sw_software_fire ? 1'b1 : (st_nxt == dbs_pkg::ST_IDLE ? 1'b0 : fired_r);
      mon_act_d_r <= MONITOR_ACTIVE_IN;
    end
  end

  // Requests hold until acknowledged; a new set beats the ack
  // Monitor request wins over a coincident user soft interrupt
  always_ff @(posedge REF_CLK_IN) begin
    if (!RST_N_IN) begin
      sw_req_r   <= 1'b0;
      mon_req_r  <= 1'b0;
      skip_r     <= 1'b0;
      replay_r   <= 1'b0;
      pend_map_r <= 1'b0;
    end else begin
      mon_req_r  <= to_mon || (HALT_OPCODE_EXEC_IN && want && MONITOR_ENABLED_IN)
                    || (mon_req_r && !CPU_ACK_IN);
      sw_req_r   <= (to_soft && !to_mon) || (sw_req_r && !CPU_ACK_IN && !to_mon);
      // Resume after the halt opcode on coincidence
      skip_r     <= (want && HALT_OPCODE_EXEC_IN) || (skip_r && !CPU_ACK_IN);
      // Remember a break that lands while the monitor is busy
      replay_r   <= (HALT_REQUEST_ENABLES_IN && brk_fire && MONITOR_ACTIVE_IN)
                    || (replay_r && !mon_return);
      pend_map_r <= SOFT_INT_EXEC_IN && to_mon;
    end
  end

  assign SOFT_INT_REQ_OUT     = sw_req_r;
  assign MONITOR_REQ_OUT      = mon_req_r;
  assign SKIP_HALT_OPCODE_OUT = skip_r;
  assign TRACE_RUN_OUT        = st_r == dbs_pkg::ST_TRACE
                             || (st_r == dbs_pkg::ST_ARMED && !CAPTURE_PLACEMENT_IN
                                 && CAPTURE_SELECT_IN);
  assign SESSION_LIVE_OUT     = st_r != dbs_pkg::ST_IDLE;
  assign SEQ_STATE_OUT        = seq_r;
  assign TRACE_COUNT_OUT      = cnt_r;

  // ---------------------------------------------------------------
  // Checks
  // ---------------------------------------------------------------
  chk_req_holds: assert property (@(posedge REF_CLK_IN) disable iff (!RST_N_IN)
    MONITOR_REQ_OUT && !CPU_ACK_IN |=> MONITOR_REQ_OUT)
    else $error("monitor request dropped before ack");

  chk_no_both_req: assert property (@(posedge REF_CLK_IN) disable iff (!RST_N_IN)
    $rose(MONITOR_REQ_OUT) |-> !$rose(SOFT_INT_REQ_OUT))
    else $error("soft interrupt raised with monitor entry");

  chk_monitor_blocks: assert property (@(posedge REF_CLK_IN) disable iff (!RST_N_IN)
    MONITOR_ACTIVE_IN && st_r == dbs_pkg::ST_ARMED && !SOFTWARE_FIRE_IN |=> seq_r == $past(seq_r))
    else $error("sequencer moved while monitor active");

  chk_immediate_brk: assert property (@(posedge REF_CLK_IN) disable iff (!RST_N_IN)
    st_r == dbs_pkg::ST_PEND && IMMEDIATE_HALT_SEL_IN |=> st_r == dbs_pkg::ST_DONE)
    else $error("immediate halt did not end the session");

  chk_begin_waits: assert property (@(posedge REF_CLK_IN) disable iff (!RST_N_IN)
    st_r == dbs_pkg::ST_TRACE && !buf_full |-> !brk_fire)
    else $error("break before begin-aligned trace completed");

  chk_fire_final: assert property (@(posedge REF_CLK_IN) disable iff (!RST_N_IN)
    sw_software_fire |=> seq_r == dbs_pkg::SEQ_FINAL && st_r == dbs_pkg::ST_PEND)
    else $error("software fire did not force Final");

  chk_fire_ignored: assert property (@(posedge REF_CLK_IN) disable iff (!RST_N_IN)
    st_r == dbs_pkg::ST_TRACE |=> st_r != dbs_pkg::ST_PEND)
    else $error("late fire restarted the session");

  chk_no_enable: assert property (@(posedge REF_CLK_IN) disable iff (!RST_N_IN)
    !HALT_REQUEST_ENABLES_IN && !sw_req_r && !CPU_ACK_IN |=> !$rose(SOFT_INT_REQ_OUT))
    else $error("break raised with halt enables clear");

  // A fired session keeps the sequencer frozen; late matches change nothing
  chk_fired_frozen: assert property (@(posedge REF_CLK_IN) disable iff (!RST_N_IN)
    fired_r && (st_r == dbs_pkg::ST_TRACE || st_r == dbs_pkg::ST_PEND) |=> $stable(seq_r))
    else $error("sequencer moved after a fired trace started");

  chk_replay_soft: assert property (@(posedge REF_CLK_IN) disable iff (!RST_N_IN)
    replay_r && mon_return && map_sel == dbs_pkg::MAP_SOFTINT
    && !(HALT_OPCODE_EXEC_IN && MONITOR_ENABLED_IN) |=> SOFT_INT_REQ_OUT)
    else $error("unserviced break not replayed on monitor return");

  chk_mon_over_soft: assert property (@(posedge REF_CLK_IN) disable iff (!RST_N_IN)
    pend_map_r |-> MONITOR_REQ_OUT && !SOFT_INT_REQ_OUT)
    else $error("user soft interrupt not deferred behind monitor entry");

  chk_halt_skip: assert property (@(posedge REF_CLK_IN) disable iff (!RST_N_IN)
    want && HALT_OPCODE_EXEC_IN |=> SKIP_HALT_OPCODE_OUT)
    else $error("resume point not moved past halt opcode");

  chk_halt_to_mon: assert property (@(posedge REF_CLK_IN) disable iff (!RST_N_IN)
    want && HALT_OPCODE_EXEC_IN && MONITOR_ENABLED_IN && !SOFT_INT_REQ_OUT
    |=> MONITOR_REQ_OUT && !SOFT_INT_REQ_OUT)
    else $error("halt opcode coincidence did not enter monitor");

  chk_no_trace_brk: assert property (@(posedge REF_CLK_IN) disable iff (!RST_N_IN)
    st_r == dbs_pkg::ST_PEND && !CAPTURE_SELECT_IN |=> st_r == dbs_pkg::ST_DONE)
    else $error("break deferred with no trace session selected");

  chk_full_breaks: assert property (@(posedge REF_CLK_IN) disable iff (!RST_N_IN)
    st_r == dbs_pkg::ST_TRACE && buf_full |=> st_r == dbs_pkg::ST_DONE)
    else $error("full trace buffer did not end the session");

endmodule

`default_nettype wire

// File: tb/dbs_cpu_model.sv
/*
  CPU-side partner: acknowledges breakpoint requests after a set wait.
  Assumes requests are held by the sequencer until this acknowledge.
*/
`timescale 1ns/100ps
`default_nettype none

module dbs_cpu_model (
  input  wire logic       clk_in,
  input  wire logic       rst_n_in,
  input  wire logic       soft_req_in,
  input  wire logic       mon_req_in,
  input  wire logic [3:0] ack_wait_in,
  output logic            ack_out
);
  logic [3:0] wait_r;

  // One-cycle acknowledge after the wait; a slow answer shows whether requests stand
  always_ff @(posedge clk_in) begin
    if (!rst_n_in || ack_out) begin
      wait_r  <= 4'h0;
      ack_out <= 1'b0;
    end else if (soft_req_in || mon_req_in) begin
      if (wait_r == ack_wait_in) begin
        ack_out <= 1'b1;
      end else begin
        wait_r <= wait_r + 4'h1;
      end
    end else begin
      wait_r <= 4'h0;
    end
  end
endmodule
`default_nettype wire

// File: tb/test_dbs_top.sv
/*
  Self-checking bench for the breakpoint sequencer, built on scenario tasks.
  Assumes dbs_pkg, dbs_top and the CPU model are compiled first.
*/
`timescale 1ns/100ps
`default_nettype none

module test_dbs_top;
  logic       clk = 1'b0, rst_n = 1'b0, live = 1'b0, fire = 1'b0, msel = 1'b0;
  logic       csel = 1'b0, cpl = 1'b0, imm = 1'b0, hre = 1'b0, men = 1'b0;
  logic       mact = 1'b0, sstep = 1'b0, hop = 1'b0, sex = 1'b0, step = 1'b0;
  logic       h0 = 1'b0, h1 = 1'b0, h2 = 1'b0, rh = 1'b0, dh = 1'b0;
  logic [3:0] scr1 = 4'h0;
  logic [2:0] omark = 3'h0, mexec = 3'h0;
  logic       ack, sreq, mreq, skip, trun, slive;
  logic [1:0] seq;
  logic [dbs_pkg::CNT_WIDTH-1:0] cnt;
  int         fails = 0, checks = 0, n;

  always #5 clk = ~clk;

  dbs_top dut_u (.REF_CLK_IN(clk), .RST_N_IN(rst_n), .SESSION_LIVE_SET_IN(live),
    .SOFTWARE_FIRE_IN(fire), .MONITOR_SELECT_IN(msel), .CAPTURE_SELECT_IN(csel),
    .CAPTURE_PLACEMENT_IN(cpl), .IMMEDIATE_HALT_SEL_IN(imm), .HALT_REQUEST_ENABLES_IN(hre),
    .SCR1_IN(scr1), .SCR2_IN(4'h1), .SCR3_IN(4'h1), .OPCODE_MARK_IN(omark),
    .RANGE_MODE_IN(1'b0), .DATA_MATCH_EN_IN(1'b0), .CHANNEL_ZERO_HIT_IN(h0),
    .CHANNEL_ONE_HIT_IN(h1), .CHANNEL_TWO_HIT_IN(h2), .RANGE_HIT_IN(rh), .DATA_HIT_IN(dh),
    .MARK_AT_EXEC_IN(mexec), .TRACE_STEP_IN(step), .MONITOR_ENABLED_IN(men),
    .MONITOR_ACTIVE_IN(mact), .SINGLE_STEP_CMD_IN(sstep), .HALT_OPCODE_EXEC_IN(hop),
    .SOFT_INT_EXEC_IN(sex), .CPU_ACK_IN(ack), .SOFT_INT_REQ_OUT(sreq), .MONITOR_REQ_OUT(mreq),
    .SKIP_HALT_OPCODE_OUT(skip), .TRACE_RUN_OUT(trun), .SESSION_LIVE_OUT(slive),
    .SEQ_STATE_OUT(seq), .TRACE_COUNT_OUT(cnt));

  dbs_cpu_model cpu_u (.clk_in(clk), .rst_n_in(rst_n), .soft_req_in(sreq), .mon_req_in(mreq),
    .ack_wait_in(4'h8), .ack_out(ack));

  // ------------------------------------------------------------
  // Shared tasks
  // ------------------------------------------------------------
  task automatic conclude();
    $display("checks %0d fails %0d", checks, fails);
    if (fails == 0 && checks > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask

  task automatic chk(input logic got, input logic exp, input string msg);
    checks++;
    if (got !== exp) begin
      fails++;
      $display("mismatch at %0t: %s", $time, msg);
    end
  endtask

  // Bounded wait for either request; runs out quietly when none is due
  task automatic wait_req();
    n = 0;
    while (sreq !== 1'b1 && mreq !== 1'b1 && n < 16) begin
      @(negedge clk);
      n++;
    end
  endtask

  // Which request came, that it stands while the CPU is slow, then retire the session
  task automatic settle(input logic es, input logic em, input logic ek);
    chk(sreq, es, "soft interrupt request");
    chk(mreq, em, "monitor request");
    chk(skip, ek, "resume after halt opcode");
    if (es | em) begin
      repeat (4) @(negedge clk);
      chk(sreq | mreq, 1'b1, "request dropped before acknowledge");
    end
    n = 0;
    while ((sreq !== 1'b0 || mreq !== 1'b0 || slive !== 1'b0) && n < 40) begin
      @(negedge clk);
      n++;
    end
    chk(sreq | mreq | slive, 1'b0, "session did not retire");
  endtask

  // One write arms and fires together; halt and soft opcodes stand until the decision
  task automatic run(input logic [7:0] cfg, input logic es, input logic em);
    @(negedge clk);
    {csel, cpl, imm, hre, msel, men, hop, sex} = cfg;
    live = 1'b1;
    fire = 1'b1;
    @(negedge clk);
    {live, fire} = 2'h0;
    wait_req();
    {hop, sex} = 2'h0;
    settle(es, em, cfg[1]);
  endtask

  task automatic hit0();
    live = 1'b1;
    @(negedge clk);
    live = 1'b0;
    h0 = 1'b1;
    @(negedge clk);
    h0 = 1'b0;
  endtask

  // ------------------------------------------------------------
  // Scenarios
  // ------------------------------------------------------------
  initial begin
    repeat (10) @(negedge clk);
    chk(seq === dbs_pkg::SEQ_STATE1 && {sreq, mreq, trun, slive} === 4'h0, 1'b1, "reset");
    rst_n = 1'b1;
    run(8'h10, 1'b1, 1'b0);
    run(8'h1C, 1'b0, 1'b1);
    run(8'h18, 1'b1, 1'b0);
    run(8'h00, 1'b0, 1'b0);
    run(8'h90, 1'b1, 1'b0);
    run(8'h80, 1'b0, 1'b0);
    run(8'hF0, 1'b1, 1'b0);
    run(8'hE0, 1'b0, 1'b0);
    run(8'h1D, 1'b0, 1'b1);
    run(8'h16, 1'b0, 1'b1);
    // Begin-aligned trace: later fires and hits must not cut it short
    {csel, cpl, imm, hre, msel, men} = 6'h34;
    live = 1'b1;
    fire = 1'b1;
    @(negedge clk);
    {live, fire} = 2'h0;
    n = 0;
    while (trun !== 1'b1 && n < 16) begin
      @(negedge clk);
      n++;
    end
    {fire, h0, h1, h2, rh, dh} = 6'h3F;
    repeat (dbs_pkg::TRACE_DEPTH - 1) begin
      step = 1'b1;
      @(negedge clk);
      {fire, h0, h1, h2, rh, dh} = 6'h00;
    end
    step = 1'b0;
    @(negedge clk);
    chk(cnt === dbs_pkg::CNT_FULL - 7'h01, 1'b1, "trace count");
    chk(sreq | mreq, 1'b0, "break before trace completed");
    step = 1'b1;
    @(negedge clk);
    step = 1'b0;
    wait_req();
    settle(1'b1, 1'b0, 1'b0);
    // Comparator hit straight to Final, then through a marked opcode
    {csel, cpl, imm, hre, msel, men} = 6'h04;
    hit0();
    wait_req();
    settle(1'b1, 1'b0, 1'b0);
    omark = 3'h1;
    hit0();
    repeat (6) @(negedge clk);
    chk(sreq | mreq, 1'b0, "break before marked opcode executed");
    mexec = 3'h1;
    @(negedge clk);
    mexec = 3'h0;
    omark = 3'h0;
    wait_req();
    settle(1'b1, 1'b0, 1'b0);
    // Monitor active: hits ignored, a forced break waits for the monitor to return
    {mact, sstep} = 2'h3;
    hit0();
    repeat (6) @(negedge clk);
    chk(sreq | mreq, 1'b0, "hit acted while monitor active");
    fire = 1'b1;
    @(negedge clk);
    fire = 1'b0;
    repeat (6) @(negedge clk);
    chk(sreq | mreq, 1'b0, "break while monitor active");
    {mact, sstep} = 2'h0;
    wait_req();
    settle(1'b1, 1'b0, 1'b0);
    conclude();
  end

  // Whole run is some hundreds of cycles; this margin only catches a hang
  initial begin
    #200000;
    fails++;
    conclude();
  end
endmodule
`default_nettype wire
